// *** rtl/irq_priority_sysctl_defs.vh ***
/*
  Constants for the interrupt priority and system control register slice:
  base address, register offsets, reset values, field layout and bus codes.
  Assumes it is included by bare name from the design files under rtl/.
*/
// Function
// R1 - A 2-bit priority code of 0 is the most urgent level and 3 the least urgent.
// R2 - Interrupts 20 to 23 sit at bits [7:6], [15:14], [23:22] and [31:30] of their register.
// R3 - The register for interrupts 24 to 27 sits at offset 0x418, same layout, reset zero.
// R4 - The register for interrupts 28 to 31 sits at 0x41c, with 31 at [31:30] and 28 at [7:6].
// R5 - Every register here is decoded relative to the control space base 0xe000e000.
// R6 - The processor identification word at 0xd00 is fixed and ignores writes.
// R7 - The interrupt control state word at 0xd04 is read/write and resets to zero.
// R8 - The application interrupt and reset control word at 0xd0c resets to 0xfa050000.
// R9 - The first system handler priority word at 0xd1c is read/write and resets to zero.
// R10 - The second system handler priority word at 0xd20 is read/write and resets to zero.
// R11 - Reserved bits [5:0], [13:8], [21:16], [29:24] of priority words read zero, ignore writes.
`ifndef IRQ_PRIORITY_SYSCTL_DEFS_VH
`define IRQ_PRIORITY_SYSCTL_DEFS_VH

// control space base, full byte address
`define CONTROL_SPACE_BASE      32'he000e000

// register byte offsets from the base
`define OFS_IRQ20_23_PRIORITY   12'h414
`define OFS_IRQ24_27_PRIORITY   12'h418
`define OFS_IRQ28_31_PRIORITY   12'h41c
`define OFS_PROCESSOR_ID        12'hd00
`define OFS_INT_CONTROL_STATE   12'hd04
`define OFS_APP_INT_RESET_CTRL  12'hd0c
`define OFS_SYSTEM_CONTROL      12'hd10
`define OFS_SYS_HANDLER_PRI_A   12'hd1c
`define OFS_SYS_HANDLER_PRI_B   12'hd20
`define OFS_ARBITER_STATUS      12'he00

// reset values
`define RST_PRIORITY            32'h00000000
`define RST_INT_CONTROL_STATE   32'h00000000
`define RST_APP_INT_RESET_CTRL  32'hfa050000
`define RST_SYSTEM_CONTROL      32'h00000000
`define RST_SYS_HANDLER_PRI     32'h00000000

// priority word layout: a 2-bit level at the top of each byte lane
`define PRI_FIELD_MASK          32'hc0c0c0c0
`define PRI_FIELD_LSB           6
`define PRI_LANE_BITS           8
`define PRI_FIELDS_PER_WORD     4

// arbiter status word layout
`define STAT_VALID_BIT          31
`define STAT_LEVEL_LSB          8
`define STAT_IRQ_LSB            0

// first interrupt number held by this slice
`define FIRST_IRQ               20

// AXI response codes
`define RESP_OKAY               2'b00
`define RESP_SLVERR             2'b10

`endif

// *** rtl/irq_level_arbiter.v ***
/*
  Picks the most urgent pending interrupt among a group of priority levels.
  Assumes pending inputs and levels are already in the aclk domain.
*/
`timescale 1ns/1ps
`include "irq_priority_sysctl_defs.vh"

module irq_level_arbiter #(
    parameter NUM   = 12,
    parameter FIRST = `FIRST_IRQ
) (
    // clock and reset
    input  wire                 aclk,
    input  wire                 aresetn,
    // request side
    input  wire [NUM-1:0]       pending,
    input  wire [2*NUM-1:0]     levels,
    // winner, registered
    output reg                  best_valid_q,
    output reg  [4:0]           best_irq_q,
    output reg  [1:0]           best_level_q
);

    reg         found_d;
    reg [1:0]   level_d;
    reg [4:0]   irq_d;
    integer     i;
    integer     num_i;

    // lowest code wins; strict compare keeps the lower number on a tie
    always @* begin
        found_d = 1'b0;
        level_d = 2'd3;
        irq_d   = 5'd0;
        num_i   = 0;
        for (i = 0; i < NUM; i = i + 1) begin
            if (pending[i] && (!found_d || levels[2*i +: 2] < level_d)) begin // R1
                found_d = 1'b1;
                level_d = levels[2*i +: 2];
                num_i   = FIRST + i;
                irq_d   = num_i[4:0];
            end
        end
    end

    // registered winner, so the answer is one cycle behind its inputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            best_valid_q <= 1'b0;
            best_irq_q   <= 5'd0;
            best_level_q <= 2'd0;
        end else begin
            best_valid_q <= found_d;
            best_irq_q   <= irq_d;
            best_level_q <= level_d;
        end
    end

endmodule // irq_level_arbiter

// *** rtl/irq_priority_sysctl_regs.v ***
/*
  AXI4-Lite register slice: priority words for interrupts 20..31, the system
  control words, and a status word showing the current arbitration winner.
  Writes to the fixed identification and status words answer OKAY and store
  nothing; unmapped offsets answer SLVERR.
  Byte strobes merge into the old word; addr[1:0] is ignored.
  Assumes one AXI4-Lite master on aclk; irq_pending arrives from outside the
  clock domain and is synchronised here.
  Assumes at most one write and one read in flight; a further request simply
  waits on the ready outputs.
*/
`timescale 1ns/1ps
`include "irq_priority_sysctl_defs.vh"

module irq_priority_sysctl_regs #(
    parameter NUM_IRQ        = 12,
    parameter PROCESSOR_ID   = 32'h5a5a0001  // arbitrary value, not a real part code
) (
    // clock and reset
    input  wire                 aclk,
    input  wire                 aresetn,
    // write address channel
    input  wire [31:0]          awaddr,
    input  wire [2:0]           awprot,
    input  wire                 awvalid,
    output wire                 awready,
    // write data channel
    input  wire [31:0]          wdata,
    input  wire [3:0]           wstrb,
    input  wire                 wvalid,
    output wire                 wready,
    // write response channel
    output wire [1:0]           bresp,
    output wire                 bvalid,
    input  wire                 bready,
    // read address channel
    input  wire [31:0]          araddr,
    input  wire [2:0]           arprot,
    input  wire                 arvalid,
    output wire                 arready,
    // read data channel
    output wire [31:0]          rdata,
    output wire [1:0]           rresp,
    output wire                 rvalid,
    input  wire                 rready,
    // interrupt requests and arbitration result
    input  wire [NUM_IRQ-1:0]   irq_pending,
    output wire                 best_valid,
    output wire [4:0]           best_irq,
    output wire [1:0]           best_level,
    // control words for the rest of the core
    output wire [31:0]          interrupt_control_state,
    output wire [31:0]          app_interrupt_reset_control,
    output wire [31:0]          system_control,
    output wire [31:0]          system_handler_priority_a,
    output wire [31:0]          system_handler_priority_b
);

    localparam NUM_PRI_WORDS = (NUM_IRQ + `PRI_FIELDS_PER_WORD - 1) / `PRI_FIELDS_PER_WORD;

    // priority words, one per four interrupts
    reg  [31:0]         pri_q [0:NUM_PRI_WORDS-1];
    reg  [31:0]         ctrl_state_q;
    reg  [31:0]         app_reset_q;
    reg  [31:0]         sys_ctrl_q;
    reg  [31:0]         handler_a_q;
    reg  [31:0]         handler_b_q;

    // bus answers, registered and driven onto the response ports
    reg                 bvalid_q;
    reg  [1:0]          bresp_q;
    reg                 rvalid_q;
    reg  [31:0]         rdata_q;
    reg  [1:0]          rresp_q;

    // write channel holding state
    reg                 aw_held_q;
    reg  [31:0]         aw_addr_q;
    reg                 w_held_q;
    reg  [31:0]         w_data_q;
    reg  [3:0]          w_strb_q;

    // pending synchroniser, first stage read only by the second
    reg  [NUM_IRQ-1:0]  pend_meta_q;
    reg  [NUM_IRQ-1:0]  pend_sync_q;

    wire [2*NUM_IRQ-1:0] levels;
    wire [31:0]          byte_mask;
    wire                 do_write;
    wire                 wr_in_space;
    wire                 rd_in_space;
    wire [11:0]          wr_ofs;
    wire [11:0]          rd_ofs;
    reg                  wr_hit;
    reg                  rd_hit;
    reg  [31:0]          rd_word;
    reg  [31:0]          wr_old;
    wire [31:0]          wr_merged;
    wire [31:0]          status_word;
    integer              n;

    // one request of each kind at a time: ready drops while one is held
    assign awready = !aw_held_q && !bvalid;
    assign wready  = !w_held_q && !bvalid;
    assign arready = !rvalid;

    // the page above the 4 KiB control space must match the base
    assign wr_in_space = ({aw_addr_q[31:12], 12'h000} == `CONTROL_SPACE_BASE); // R5
    assign rd_in_space = ({araddr[31:12], 12'h000} == `CONTROL_SPACE_BASE);    // R5

    // word offsets inside the page; the byte lane bits are dropped
    assign wr_ofs      = {aw_addr_q[11:2], 2'b00};
    assign rd_ofs      = {araddr[11:2], 2'b00};
    assign do_write    = aw_held_q && w_held_q && !bvalid;

    // byte lane enables expanded to bits
    assign byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wr_merged = (w_data_q & byte_mask) | (wr_old & ~byte_mask);

    // unpack one level per interrupt from the top two bits of each byte lane
    genvar k;
    generate
        for (k = 0; k < NUM_IRQ; k = k + 1) begin : g_level
            localparam integer WRD = k / `PRI_FIELDS_PER_WORD;
            localparam integer BIT = (k % `PRI_FIELDS_PER_WORD) * `PRI_LANE_BITS
                                     + `PRI_FIELD_LSB;
            assign levels[2*k]   = pri_q[WRD][BIT];     // R2
            assign levels[2*k+1] = pri_q[WRD][BIT+1];   // R2
        end
    endgenerate

    // the arbitration result is the block's own state, readable by software
    assign status_word = ({31'd0, best_valid} << `STAT_VALID_BIT)
                       | ({30'd0, best_level} << `STAT_LEVEL_LSB)
                       | ({27'd0, best_irq} << `STAT_IRQ_LSB);

    // read decode; unmapped offsets answer zero with an error response
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = rd_in_space;
        case (rd_ofs)
            `OFS_IRQ20_23_PRIORITY:  rd_word = pri_q[0] & `PRI_FIELD_MASK;  // R11
            `OFS_IRQ24_27_PRIORITY:  rd_word = pri_q[1] & `PRI_FIELD_MASK;  // R3
            `OFS_IRQ28_31_PRIORITY:  rd_word = pri_q[2] & `PRI_FIELD_MASK;  // R4
            `OFS_PROCESSOR_ID:       rd_word = PROCESSOR_ID;                // R6
            `OFS_INT_CONTROL_STATE:  rd_word = ctrl_state_q;                // R7
            `OFS_APP_INT_RESET_CTRL: rd_word = app_reset_q;                 // R8
            `OFS_SYSTEM_CONTROL:     rd_word = sys_ctrl_q;
            `OFS_SYS_HANDLER_PRI_A:  rd_word = handler_a_q;                 // R9
            `OFS_SYS_HANDLER_PRI_B:  rd_word = handler_b_q;                 // R10
            `OFS_ARBITER_STATUS:     rd_word = status_word;
            default:                 rd_hit  = 1'b0;
        endcase
        // off the page the offset match alone must not leak a register
        if (!rd_in_space) begin
            rd_word = 32'h00000000;
        end
    end

    // current value of the write target, for byte-lane merging
    always @* begin
        wr_old = 32'h00000000;
        wr_hit = wr_in_space;
        case (wr_ofs)
            `OFS_IRQ20_23_PRIORITY:  wr_old = pri_q[0];
            `OFS_IRQ24_27_PRIORITY:  wr_old = pri_q[1];
            `OFS_IRQ28_31_PRIORITY:  wr_old = pri_q[2];
            `OFS_PROCESSOR_ID:       wr_old = PROCESSOR_ID;
            `OFS_INT_CONTROL_STATE:  wr_old = ctrl_state_q;
            `OFS_APP_INT_RESET_CTRL: wr_old = app_reset_q;
            `OFS_SYSTEM_CONTROL:     wr_old = sys_ctrl_q;
            `OFS_SYS_HANDLER_PRI_A:  wr_old = handler_a_q;
            `OFS_SYS_HANDLER_PRI_B:  wr_old = handler_b_q;
            `OFS_ARBITER_STATUS:     wr_old = status_word;
            default:                 wr_hit = 1'b0;
        endcase
        if (!wr_in_space) begin
            wr_hit = 1'b0;
        end
    end

    // write channels: address and data are caught in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            // both halves are spent by the write they formed
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    // write response: stands until taken, and keeps both readies low meanwhile
    always @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;  // R5
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // register storage; the identification and status words take no write
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (n = 0; n < NUM_PRI_WORDS; n = n + 1) begin
                pri_q[n] <= `RST_PRIORITY;                               // R3
            end
            ctrl_state_q <= `RST_INT_CONTROL_STATE;                      // R7
            app_reset_q  <= `RST_APP_INT_RESET_CTRL;                     // R8
            sys_ctrl_q   <= `RST_SYSTEM_CONTROL;
            handler_a_q  <= `RST_SYS_HANDLER_PRI;                        // R9
            handler_b_q  <= `RST_SYS_HANDLER_PRI;                        // R10
        end else if (do_write && wr_hit) begin
            case (wr_ofs)
                `OFS_IRQ20_23_PRIORITY:  pri_q[0] <= wr_merged & `PRI_FIELD_MASK; // R11
                `OFS_IRQ24_27_PRIORITY:  pri_q[1] <= wr_merged & `PRI_FIELD_MASK; // R3
                `OFS_IRQ28_31_PRIORITY:  pri_q[2] <= wr_merged & `PRI_FIELD_MASK; // R4
                `OFS_INT_CONTROL_STATE:  ctrl_state_q <= wr_merged;      // R7
                `OFS_APP_INT_RESET_CTRL: app_reset_q  <= wr_merged;      // R8
                `OFS_SYSTEM_CONTROL:     sys_ctrl_q   <= wr_merged;
                `OFS_SYS_HANDLER_PRI_A:  handler_a_q  <= wr_merged;      // R9
                `OFS_SYS_HANDLER_PRI_B:  handler_b_q  <= wr_merged;      // R10
                // fixed words: the write is answered OKAY but nothing is stored
                `OFS_PROCESSOR_ID:       ;                               // R6
                `OFS_ARBITER_STATUS:     ;
                default:                 ;
            endcase
        end
    end

    // read channel: data is sampled at the address handshake and held
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // two-stage synchroniser, requests come from other clock domains
    always @(posedge aclk) begin
        if (!aresetn) begin
            pend_meta_q <= {NUM_IRQ{1'b0}};
            pend_sync_q <= {NUM_IRQ{1'b0}};
        end else begin
            pend_meta_q <= irq_pending;
            pend_sync_q <= pend_meta_q;
        end
    end

    // most urgent pending request; costs one cycle after the synchroniser
    irq_level_arbiter #(
        .NUM   (NUM_IRQ),
        .FIRST (`FIRST_IRQ)
    ) u_arbiter (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .pending      (pend_sync_q),
        .levels       (levels),
        .best_valid_q (best_valid),
        .best_irq_q   (best_irq),
        .best_level_q (best_level)
    );

    // control words straight from their registers
    assign interrupt_control_state     = ctrl_state_q;
    assign app_interrupt_reset_control = app_reset_q;
    assign system_control              = sys_ctrl_q;
    assign system_handler_priority_a   = handler_a_q;
    assign system_handler_priority_b   = handler_b_q;

    // response ports follow their registers
    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

endmodule // irq_priority_sysctl_regs

// *** testbench/irq_priority_sysctl_regs_assertions.sv ***
/* concurrent checks on the bus handshakes, reset values and read-back paths of the
   register slice. assumes a bind to irq_priority_sysctl_regs and one aclk domain. */
`timescale 1ns/1ps
module irq_priority_sysctl_regs_assertions #(
    parameter PROCESSOR_ID = 32'h0
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    // read channels
    input wire logic [31:0] araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    // arbitration and control words
    input wire logic        best_valid,
    input wire logic [4:0]  best_irq,
    input wire logic [31:0] interrupt_control_state,
    input wire logic [31:0] app_interrupt_reset_control,
    input wire logic [31:0] system_handler_priority_b
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // read decode helpers, reused by several properties
    wire in_page = araddr[31:12] == 20'he000e;
    wire rd_go   = arvalid && arready;

    property p_b_stands; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_stands: assert property (p_b_stands)
        else $error("write response dropped early");
    property p_r_stands; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_stands: assert property (p_r_stands)
        else $error("read response dropped early");
    property p_r_answer; rd_go |=> rvalid; endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read answer late");
    property p_ar_block; rvalid |-> !arready; endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read address taken while answer pending");
    property p_w_answer; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
    endproperty
    a_w_answer: assert property (p_w_answer)
        else $error("write answer timing wrong");
    property p_reset_vals; $rose(aresetn) |-> app_interrupt_reset_control == 32'hfa050000
        && interrupt_control_state == 32'h0 && system_handler_priority_b == 32'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("control word not at reset value");
    property p_out_page; rd_go && !in_page |=> rresp == 2'b10 && rdata == 32'h0; endproperty
    a_out_page: assert property (p_out_page)
        else $error("read outside page not refused");
    property p_id; rd_go && in_page && araddr[11:0] == 12'hd00 |=> rdata == PROCESSOR_ID;
    endproperty
    a_id: assert property (p_id)
        else $error("identification word wrong");
    property p_state_rd; rd_go && in_page && araddr[11:0] == 12'hd04
        |=> rdata == $past(interrupt_control_state); endproperty
    a_state_rd: assert property (p_state_rd)
        else $error("control state read mismatch");
    property p_handler_rd; rd_go && in_page && araddr[11:0] == 12'hd20
        |=> rdata == $past(system_handler_priority_b); endproperty
    a_handler_rd: assert property (p_handler_rd)
        else $error("handler priority read mismatch");
    property p_pri_rsvd; rd_go && araddr[11:4] == 8'h41 && araddr[3:2] != 2'b00
        |=> (rdata & 32'h3f3f3f3f) == 32'h0; endproperty
    a_pri_rsvd: assert property (p_pri_rsvd)
        else $error("reserved priority bits not zero");
    property p_best_range; best_valid |-> best_irq >= 5'd20 && best_irq <= 5'd31; endproperty
    a_best_range: assert property (p_best_range)
        else $error("winner outside interrupt range");
endmodule // irq_priority_sysctl_regs_assertions

bind irq_priority_sysctl_regs irq_priority_sysctl_regs_assertions #(
    .PROCESSOR_ID(PROCESSOR_ID)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .best_valid(best_valid),
    .best_irq(best_irq), .interrupt_control_state(interrupt_control_state),
    .app_interrupt_reset_control(app_interrupt_reset_control),
    .system_handler_priority_b(system_handler_priority_b));

// *** testbench/irq_priority_sysctl_regs_test.sv ***
/* self-checking bench for the register slice: table of register writes and reads,
   then arbitration, status, reset. assumes the defs header is on the include path. */
`timescale 1ns/1ps
`include "irq_priority_sysctl_defs.vh"
module irq_priority_sysctl_regs_test;
    localparam logic [31:0] ID_VALUE = 32'h3c3c0007; // arbitrary value, no real part
    localparam logic [31:0] B = `CONTROL_SPACE_BASE;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, data;
    logic [3:0] wstrb = 4'h0;
    logic [11:0] irq_pending = 12'h0;
    logic [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, best_valid;
    wire [1:0] bresp, rresp, best_level;
    wire [4:0] best_irq;
    wire [31:0] rdata, ctrl_state, app_reset, sys_ctrl, handler_a, handler_b;
    int n_mismatch = 0, checks = 0, i;
    // register table: address, write data, strobes, w-before-aw gap, read-back, response
    logic [31:0] t_addr [12] = '{B+32'h414, B+32'h418, B+32'h418, B+32'h41c, B+32'hd04,
        B+32'hd0c, B+32'hd10, B+32'hd1c, B+32'hd20, B+32'hd00, B+32'hd08, B+32'h1414};
    logic [31:0] t_wd [12] = '{32'hffffffff, 32'h7f80ffc0, 32'h0, 32'hc0000040,
        32'ha5a5a5a5, 32'h12345678, 32'h0000ffff, 32'hdeadbeef, 32'h0badf00d,
        32'hffffffff, 32'hffffffff, 32'hffffffff};
    logic [3:0] t_st [12] = '{4'hf, 4'hf, 4'h2, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf,
        4'hf, 4'hf};
    int t_gap [12] = '{0, 0, 0, 2, 0, 0, 0, 3, 0, 0, 0, 0};
    logic [31:0] t_rd [12] = '{32'hc0c0c0c0, 32'h4080c0c0, 32'h408000c0, 32'hc0000040,
        32'ha5a5a5a5, 32'h12345678, 32'h0000ffff, 32'hdeadbeef, 32'h0badf00d, ID_VALUE,
        32'h0, 32'h0};
    logic [1:0] t_rs [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h2, 2'h2};
    // reset values and arbitration cases
    logic [11:0] r_ofs [8] = '{12'h414, 12'h418, 12'h41c, 12'hd04, 12'hd0c, 12'hd10,
        12'hd1c, 12'hd20};
    logic [31:0] r_val [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hfa050000, 32'h0, 32'h0, 32'h0};
    logic [11:0] a_pend [4] = '{12'h0c0, 12'h101, 12'h000, 12'h220};
    logic [7:0] a_exp [4] = '{{1'b1, 5'd27, 2'd1}, {1'b1, 5'd28, 2'd1}, 8'h00,
        {1'b1, 5'd25, 2'd0}};

    irq_priority_sysctl_regs #(.NUM_IRQ(12), .PROCESSOR_ID(ID_VALUE)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq_pending(irq_pending), .best_valid(best_valid), .best_irq(best_irq),
        .best_level(best_level), .interrupt_control_state(ctrl_state),
        .app_interrupt_reset_control(app_reset), .system_control(sys_ctrl),
        .system_handler_priority_a(handler_a), .system_handler_priority_b(handler_b));

    always #4 aclk = ~aclk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // handshakes judged at the falling edge, so the rising edge never races the design
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [3:0] s, input int gap, output logic [1:0] r);
        int n;
        logic tw, ta, tb, rb;
        r = 2'bxx;
        awaddr <= a; wdata <= d; wstrb <= s; wvalid <= 1'b1; awvalid <= (gap == 0);
        for (n = 1; n < 100; n++) begin
            @(negedge aclk);
            tw = wvalid && wready; ta = awvalid && awready;
            tb = bvalid && bready; rb = bvalid && !bready;
            if (tb) r = bresp;
            @(posedge aclk);
            if (tw) wvalid <= 1'b0;
            if (ta) awvalid <= 1'b0;
            if (n == gap) awvalid <= 1'b1;
            if (rb) bready <= 1'b1; // late ready stalls the response one cycle
            if (tb) break;
        end
        bready <= 1'b0;
        chk({31'h0, tb}, 32'h1);
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        logic ta, tr, rv;
        d = 'x; r = 2'bxx;
        araddr <= a; arvalid <= 1'b1;
        for (n = 1; n < 100; n++) begin
            @(negedge aclk);
            ta = arvalid && arready; tr = rvalid && rready; rv = rvalid && !rready;
            if (tr) begin d = rdata; r = rresp; end
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (rv) rready <= 1'b1;
            if (tr) break;
        end
        rready <= 1'b0;
        chk({31'h0, tr}, 32'h1);
        @(posedge aclk);
    endtask

    task reset_check;
        for (int j = 0; j < 8; j++) begin
            axi_read(B + {20'h0, r_ofs[j]}, data, resp);
            chk(data, r_val[j]);
        end
        chk(app_reset, 32'hfa050000);
        chk(ctrl_state, 32'h0);
        chk(sys_ctrl, 32'h0);
        chk(handler_a, 32'h0);
        chk(handler_b, 32'h0);
        chk({31'h0, best_valid}, 32'h0);
    endtask

    task wrap_up;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        reset_check;
        for (i = 0; i < 12; i++) begin
            axi_write(t_addr[i], t_wd[i], t_st[i], t_gap[i], resp);
            chk({30'h0, resp}, {30'h0, t_rs[i]});
            axi_read(t_addr[i], data, resp);
            chk(data, t_rd[i]);
            chk({30'h0, resp}, {30'h0, t_rs[i]});
        end
        // the control words must also appear on their own output ports
        chk(ctrl_state, 32'ha5a5a5a5);
        chk(app_reset, 32'h12345678);
        chk(sys_ctrl, 32'h0000ffff);
        chk(handler_a, 32'hdeadbeef);
        chk(handler_b, 32'h0badf00d);
        // sync stages plus the arbiter register give three edges of delay
        for (i = 0; i < 4; i++) begin
            @(posedge aclk);
            irq_pending <= a_pend[i];
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk({24'h0, best_valid, best_valid ? {best_irq, best_level} : 7'h0},
                {24'h0, a_exp[i]});
        end
        axi_read(B + 32'he00, data, resp);
        chk(data, 32'h80000019);
        axi_write(B + 32'h418, 32'h4080c0c0, 4'hf, 0, resp);
        @(negedge aclk);
        chk({25'h0, best_valid, best_irq, best_level}, {25'h0, 1'b1, 5'd29, 2'd0});
        // second reset in mid-run must restore every word
        @(posedge aclk);
        aresetn <= 1'b0;
        irq_pending <= 12'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        reset_check;
        wrap_up;
    end
endmodule // irq_priority_sysctl_regs_test
